//--- src/pio_top.sv
// Proximity interrupt output logic with AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module pio_top
  import pio_pkg::*;
(
  input wire logic CLOCK, // 100 MHz clock
  input wire logic RESET, // Sync reset, active high
  input wire logic HSEL, // Slave select
  input wire logic [31:0] HADDR, // Byte address
  input wire logic [1:0] HTRANS, // Transfer type
  input wire logic HWRITE, // Write
  input wire logic [2:0] HSIZE, // Size
  input wire logic HREADY, // Bus ready
  input wire logic [31:0] HWDATA, // Write data
  output logic [31:0] HRDATA, // Read data
  output logic HREADYOUT, // Slave ready
  output logic HRESP, // Always OKAY
  input wire logic PROX_VALID, // New proximity sample strobe
  input wire logic [DATA_W-1:0] PROX_DATA, // Proximity sample
  input wire logic LIGHT_HI_EV, // Light above high threshold event
  input wire logic LIGHT_LO_EV, // Light below low threshold event
  output logic INT_N, // Sensor interrupt pin, active low
  output logic IRQ // Bus-side level interrupt
);
  import pio_pkg::*;

  logic [31:0] config_r;
  logic [DATA_W-1:0] prox_high_threshold_r;
  logic [DATA_W-1:0] prox_low_threshold_r;
  logic [FLAG_W-1:0] flags_r;
  logic [EV_W-1:0] status_r;
  logic [EV_W-1:0] irq_en_r;
  logic [DATA_W-1:0] prox_r;
  logic int_n_r;
  logic logic_prev_r;
  logic [31:0] hrdata_r;
  logic irq_r;
  logic ph_wr_r;
  logic ph_rd_r;
  logic [11:0] ph_addr_r;

  logic prox_logic_output_select;
  logic light_irq_enable;
  pio_trig_e prox_irq_trigger_select;
  logic [1:0] prox_hit_persistence;
  logic flags_read;
  logic near_event_flag_set;
  logic far_event_flag_set;
  logic light_set;
  logic addr_ok;
  logic [EV_W-1:0] ev_now;

  pio_persist_if pif ();

  assign prox_logic_output_select = config_r[CFG_LOGIC_BIT];
  assign light_irq_enable = config_r[CFG_LIGHT_BIT];
  assign prox_irq_trigger_select = pio_trig_e'(config_r[CFG_TRIG_LSB +: 2]);
  assign prox_hit_persistence = config_r[CFG_PERS_LSB +: 2];

  // Sample inputs come from the measurement engine on this clock
  assign pif.sample_stb = PROX_VALID;
  assign pif.above_high = PROX_DATA > prox_high_threshold_r;
  assign pif.below_low = PROX_DATA < prox_low_threshold_r;
  assign pif.need = prox_hit_persistence;
  assign pif.clear = 1'b0;

  pio_persist u_persist (
    .clk(CLOCK),
    .rst(RESET),
    .p(pif)
  );

  // AHB-Lite address phase capture; zero wait states
  assign addr_ok = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_addr_r <= 12'h000;
    end else begin
      ph_wr_r <= addr_ok && HWRITE;
      ph_rd_r <= addr_ok && !HWRITE;
      ph_addr_r <= HADDR[11:0];
    end
  end

  assign flags_read = ph_rd_r && (ph_addr_r == OFF_FLAGS);

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      config_r <= CONFIG_RST;
      prox_high_threshold_r <= '0;
      prox_low_threshold_r <= '0;
      irq_en_r <= '0;
    end else if (ph_wr_r) begin
      case (ph_addr_r)
        OFF_CONFIG: config_r <= HWDATA;
        OFF_HIGH_THR: prox_high_threshold_r <= HWDATA[DATA_W-1:0];
        OFF_LOW_THR: prox_low_threshold_r <= HWDATA[DATA_W-1:0];
        OFF_IRQ_EN: irq_en_r <= HWDATA[EV_W-1:0];
        default: ;
      endcase
    end
  end

  // Read data registered in the address phase so it stands in the data phase
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addr_ok && !HWRITE) begin
      case (HADDR[11:0])
        OFF_CONFIG: hrdata_r <= config_r;
        OFF_HIGH_THR: hrdata_r <= {16'h0000, prox_high_threshold_r};
        OFF_LOW_THR: hrdata_r <= {16'h0000, prox_low_threshold_r};
        OFF_FLAGS: hrdata_r <= {24'h000000, flags_r};
        OFF_STATUS: hrdata_r <= {29'h0, status_r};
        OFF_IRQ_EN: hrdata_r <= {29'h0, irq_en_r};
        OFF_PROX: hrdata_r <= {16'h0000, prox_r};
        default: hrdata_r <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      prox_r <= '0;
    end else if (PROX_VALID) begin
      prox_r <= PROX_DATA;
    end
  end

  // Event qualification by trigger select
  assign near_event_flag_set = pif.near_hit
    && (prox_irq_trigger_select == TRIG_NEAR || prox_irq_trigger_select == TRIG_BOTH);
  assign far_event_flag_set = pif.far_hit
    && (prox_irq_trigger_select == TRIG_FAR || prox_irq_trigger_select == TRIG_BOTH);
  assign light_set = light_irq_enable && !prox_logic_output_select && (LIGHT_HI_EV || LIGHT_LO_EV);

  // Flags latch; while any is pending new events are not taken
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      flags_r <= '0;
    end else if (flags_read) begin
      flags_r <= '0;
    end else if (flags_r == '0) begin
      flags_r[FLAG_NEAR] <= near_event_flag_set;
      flags_r[FLAG_FAR] <= far_event_flag_set;
      flags_r[FLAG_LIGHT_HI] <= light_set && LIGHT_HI_EV;
      flags_r[FLAG_LIGHT_LO] <= light_set && LIGHT_LO_EV;
    end
  end

  // Logic-mode near/far state with hysteresis
  always_ff @(posedge CLOCK) begin
    if (RESET || !prox_logic_output_select) begin
      logic_prev_r <= 1'b1;
    end else if (prox_irq_trigger_select != TRIG_OFF) begin
      if (pif.near_hit) begin
        logic_prev_r <= 1'b0;
      end else if (pif.far_hit) begin
        logic_prev_r <= 1'b1;
      end
    end
  end

  // Pin selection between modes
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      int_n_r <= 1'b1;
    end else if (prox_logic_output_select) begin
      int_n_r <= (prox_irq_trigger_select == TRIG_OFF) ? 1'b1 : logic_prev_r;
    end else begin
      int_n_r <= (flags_r == '0) || flags_read;
    end
  end

  // Bus-side sticky status; set wins over clear
  assign ev_now[EV_NEAR] = pif.near_hit;
  assign ev_now[EV_FAR] = pif.far_hit;
  assign ev_now[EV_LIGHT] = LIGHT_HI_EV || LIGHT_LO_EV;

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~((ph_wr_r && ph_addr_r == OFF_IRQ_CLR) ? HWDATA[EV_W-1:0] : '0)) | ev_now;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & irq_en_r);
    end
  end

  assign INT_N = int_n_r;
  assign IRQ = irq_r;
  assign HRDATA = hrdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
endmodule
`default_nettype wire

//--- src/pio_pkg.sv
// Package: register map, field layout and encodings of the proximity interrupt block
package pio_pkg;
  localparam int DATA_W = 16;
  localparam logic [11:0] OFF_CONFIG = 12'h000;
  localparam logic [11:0] OFF_HIGH_THR = 12'h004;
  localparam logic [11:0] OFF_LOW_THR = 12'h008;
  localparam logic [11:0] OFF_FLAGS = 12'h00c;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [11:0] OFF_IRQ_EN = 12'h014;
  localparam logic [11:0] OFF_IRQ_CLR = 12'h018;
  localparam logic [11:0] OFF_PROX = 12'h01c;
  // Config word fields
  localparam int CFG_TRIG_LSB = 0;
  localparam int CFG_PERS_LSB = 2;
  localparam int CFG_LOGIC_BIT = 4;
  localparam int CFG_LIGHT_BIT = 5;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
  // Flag bits
  localparam int FLAG_FAR = 0;
  localparam int FLAG_NEAR = 1;
  localparam int FLAG_LIGHT_LO = 4;
  localparam int FLAG_LIGHT_HI = 5;
  localparam int FLAG_W = 8;
  // Interrupt status bits
  localparam int EV_NEAR = 0;
  localparam int EV_FAR = 1;
  localparam int EV_LIGHT = 2;
  localparam int EV_W = 3;
  typedef enum logic [1:0] {
    TRIG_OFF = 2'h0,
    TRIG_NEAR = 2'h1,
    TRIG_FAR = 2'h2,
    TRIG_BOTH = 2'h3
  } pio_trig_e;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

//--- src/pio_persist_if.sv
// Interface carrying one sample and the debounced threshold result
`timescale 1ns/1ps
`default_nettype none
interface pio_persist_if;
  logic sample_stb;
  logic above_high;
  logic below_low;
  logic [1:0] need;
  logic clear;
  logic near_hit;
  logic far_hit;
  modport ctl (output sample_stb, above_high, below_low, need, clear, input near_hit, far_hit);
  modport filt (input sample_stb, above_high, below_low, need, clear, output near_hit, far_hit);
endinterface
`default_nettype wire

//--- src/pio_persist.sv
// Consecutive-hit persistence filter for the proximity thresholds
`timescale 1ns/1ps
`default_nettype none
module pio_persist (
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  pio_persist_if.filt p // Sample and results
);
  logic [1:0] hi_cnt_r;
  logic [1:0] lo_cnt_r;
  logic near_hit_r;
  logic far_hit_r;

  assign p.near_hit = near_hit_r;
  assign p.far_hit = far_hit_r;

  // Count saturates at need; compare with >= so a need lowered mid-run cannot wrap the count
  always_ff @(posedge clk) begin
    if (rst || p.clear) begin
      hi_cnt_r <= 2'h0;
      lo_cnt_r <= 2'h0;
      near_hit_r <= 1'b0;
      far_hit_r <= 1'b0;
    end else begin
      near_hit_r <= 1'b0;
      far_hit_r <= 1'b0;
      if (p.sample_stb) begin
        if (p.above_high) begin
          if (hi_cnt_r >= p.need) begin
            near_hit_r <= 1'b1;
          end else begin
            hi_cnt_r <= hi_cnt_r + 2'h1;
          end
        end else begin
          hi_cnt_r <= 2'h0;
        end
        if (p.below_low) begin
          if (lo_cnt_r >= p.need) begin
            far_hit_r <= 1'b1;
          end else begin
            lo_cnt_r <= lo_cnt_r + 2'h1;
          end
        end else begin
          lo_cnt_r <= 2'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- test/pio_host.sv
// Host GPIO model that samples the sensor interrupt pin
`timescale 1ns/1ps
`default_nettype none
module pio_host (
  input wire logic clk, // Host clock
  input wire logic int_n, // Sensor pin
  output logic level // Pin level seen by host software
);
  // One sampling flop: the host never sees the pin sooner than a real port would
  always_ff @(posedge clk) begin
    level <= int_n;
  end
endmodule
`default_nettype wire

//--- test/pio_monitor.sv
// Checker on the proximity interrupt top ports
`timescale 1ns/1ps
`default_nettype none
module pio_monitor
  import pio_pkg::*;
(
  input wire logic CLOCK, // Clock
  input wire logic RESET, // Reset
  input wire logic HSEL, // Select
  input wire logic [31:0] HADDR, // Address
  input wire logic [1:0] HTRANS, // Type
  input wire logic HWRITE, // Write
  input wire logic HREADY, // Ready in
  input wire logic [31:0] HWDATA, // Write data
  input wire logic [31:0] HRDATA, // Read data
  input wire logic HREADYOUT, // Ready out
  input wire logic HRESP, // Response
  input wire logic PROX_VALID, // Sample
  input wire logic LIGHT_HI_EV, // Light high
  input wire logic LIGHT_LO_EV, // Light low
  input wire logic INT_N, // Pin
  input wire logic IRQ // Interrupt
);
  logic tk, rf, ev, off, wc_r, rf_r, lg_r;
  logic [1:0] tr_r;
  assign tk = HSEL && HREADY && HTRANS == HTRANS_NONSEQ;
  assign rf = tk && !HWRITE && HADDR[11:0] == OFF_FLAGS;
  assign ev = PROX_VALID || LIGHT_HI_EV || LIGHT_LO_EV;
  assign off = lg_r && tr_r == 2'h0;
  // Mode shadow taken from the write data phase, since the checker cannot see the config register
  always_ff @(posedge CLOCK) begin
    wc_r <= !RESET && tk && HWRITE && HADDR[11:0] == OFF_CONFIG;
    rf_r <= !RESET && rf;
    if (RESET) {lg_r, tr_r} <= 3'h0;
    else if (wc_r) {lg_r, tr_r} <= {HWDATA[CFG_LOGIC_BIT], HWDATA[CFG_TRIG_LSB+:2]};
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  sequence s_read; rf && !lg_r; endsequence
  sequence s_free; ##[1:3] INT_N; endsequence
  AST_RESET_IDLE: assert property (disable iff (1'b0) RESET |=> INT_N && !IRQ && HRDATA == 32'h0)
    else $error("pin, irq or read data not idle after reset");
  AST_READ_RELEASE: assert property (s_read |-> s_free)
    else $error("flag read did not release the pin");
  AST_HOLD_LOW: assert property (!lg_r && !$past(lg_r) && !INT_N && !rf && !$past(rf) && !$past(rf, 2) && !$past(rf, 3)
    |=> !INT_N)
    else $error("pin released without a flag read");
  AST_FALL_CAUSE: assert property ($fell(INT_N) |-> $past(ev, 2) || $past(ev, 3))
    else $error("pin fell without an event");
  AST_LOGIC_CAUSE: assert property (lg_r && $past(lg_r, 3) && $changed(INT_N) |-> $past(PROX_VALID, 3))
    else $error("logic mode pin moved without a sample");
  AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
    else $error("slave stalled or answered an error");
  AST_FLAG_BITS: assert property (rf_r |-> HRDATA[31:6] == 26'h0 && HRDATA[3:2] == 2'h0)
    else $error("flag read shows unused bits set");
  AST_TRIG_OFF: assert property (off && $past(off, 3) |-> $stable(INT_N))
    else $error("logic mode pin moved with trigger off");
endmodule
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench with a reference model of flags and pin
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pio_pkg::*;
  logic CLOCK = 1'h0, RESET = 1'h1, HSEL = 1'h0, HWRITE = 1'h0, PROX_VALID = 1'h0, LIGHT_HI_EV = 1'h0, LIGHT_LO_EV = 1'h0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd, seed = 32'hba8b;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h0;
  logic [DATA_W-1:0] PROX_DATA = 16'h0;
  logic HREADYOUT, HRESP, INT_N, IRQ, host_lvl;
  int num_errors = 0, check_count = 0, hi = 1000, lo = 200, pers, trig, lgc, flags, pin = 1, nc, fc;
  always #5 CLOCK = ~CLOCK;
  pio_top i_dut (.CLOCK, .RESET, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HREADY(HREADYOUT), .HWDATA,
    .HRDATA, .HREADYOUT, .HRESP, .PROX_VALID, .PROX_DATA, .LIGHT_HI_EV, .LIGHT_LO_EV, .INT_N, .IRQ);
  pio_host i_host (.clk(CLOCK), .int_n(INT_N), .level(host_lvl));
  task report_and_stop;
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] rnd(input int span, input int base);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return base + seed % span;
  endfunction
  task wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge CLOCK);
      i++;
    end while (HREADYOUT !== 1'h1 && i < 20);
    if (HREADYOUT !== 1'h1) begin
      num_errors++;
      report_and_stop;
    end
  endtask
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    HSEL <= 1'h1;
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= w;
    HADDR <= {20'h0, a};
    HSIZE <= 3'h2;
    wait_rdy;
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy;
    rd = HRDATA;
  endtask
  task pin_chk;
    repeat (5) @(posedge CLOCK);
    chk({31'h0, host_lvl}, 32'(pin), "pin");
  endtask
  task irq_chk(input logic e);
    repeat (2) @(posedge CLOCK);
    chk({31'h0, IRQ}, {31'h0, e}, "irq");
  endtask
  task cfg(input int t, input int p, input int l);
    trig = t;
    pers = p;
    lgc = l;
    // Light enable stays set so that logic mode has light events to ignore
    ahb(1'h1, OFF_CONFIG, 32'(t | p << CFG_PERS_LSB | l << CFG_LOGIC_BIT | 1 << CFG_LIGHT_BIT));
  endtask
  task rdfl(input int e);
    ahb(1'h0, OFF_FLAGS, 32'h0);
    chk(rd, 32'(e), "flags");
    flags = 0;
    if (lgc == 0) pin = 1;
    pin_chk;
  endtask
  task prox(input int k);
    logic [15:0] v;
    v = k == 2 ? 16'(rnd(1000, hi + 1)) : k == 1 ? 16'(rnd(hi - lo - 1, lo + 1)) : 16'(rnd(lo, 0));
    nc = v > hi ? nc + 1 : 0;
    fc = v < lo ? fc + 1 : 0;
    if (lgc != 0 && trig != 0) begin
      if (nc > pers) pin = 0;
      else if (fc > pers) pin = 1;
    end else if (lgc == 0 && flags == 0) begin
      if (nc > pers && trig[0]) flags = 2;
      else if (fc > pers && trig[1]) flags = 1;
    end
    if (lgc == 0) pin = flags == 0;
    PROX_VALID <= 1'h1;
    PROX_DATA <= v;
    @(posedge CLOCK);
    PROX_VALID <= 1'h0;
    pin_chk;
  endtask
  task light(input logic h);
    if (lgc == 0 && flags == 0) flags = h ? 32 : 16;
    if (lgc == 0) pin = flags == 0;
    if (h) LIGHT_HI_EV <= 1'h1;
    else LIGHT_LO_EV <= 1'h1;
    @(posedge CLOCK);
    LIGHT_HI_EV <= 1'h0;
    LIGHT_LO_EV <= 1'h0;
    pin_chk;
  endtask
  initial begin
    repeat (10) @(posedge CLOCK);
    RESET <= 1'h0;
    @(posedge CLOCK);
    chk({31'h0, INT_N}, 32'h1, "pin");
    ahb(1'h0, OFF_CONFIG, 32'h0);
    chk(rd, CONFIG_RST, "config");
    ahb(1'h1, OFF_HIGH_THR, 32'(hi));
    ahb(1'h1, OFF_LOW_THR, 32'(lo));
    ahb(1'h1, OFF_IRQ_EN, 32'h7);
    for (int p = 0; p < 4; p++) begin
      cfg(3, p, 0);
      prox(1);
      repeat (p + 1) prox(2);
      rdfl(2);
    end
    cfg(3, 0, 0);
    prox(2);
    prox(0);
    rdfl(2);
    light(1'h1);
    light(1'h0);
    rdfl(32);
    light(1'h0);
    rdfl(16);
    ahb(1'h1, OFF_IRQ_CLR, 32'h7);
    irq_chk(1'h0);
    prox(1);
    prox(2);
    ahb(1'h0, OFF_STATUS, 32'h0);
    chk(rd, 32'h1 << EV_NEAR, "status");
    irq_chk(1'h1);
    ahb(1'h1, OFF_IRQ_EN, 32'h0);
    irq_chk(1'h0);
    ahb(1'h1, OFF_IRQ_EN, 32'h7);
    irq_chk(1'h1);
    ahb(1'h1, OFF_IRQ_CLR, 32'h1);
    irq_chk(1'h0);
    rdfl(2);
    ahb(1'h0, 12'h040, 32'h0);
    chk(rd, 32'h0, "unmapped");
    cfg(1, 0, 0);
    prox(0);
    prox(2);
    rdfl(2);
    cfg(2, 0, 0);
    prox(2);
    prox(0);
    rdfl(1);
    cfg(3, 0, 1);
    pin_chk;
    light(1'h1);
    prox(2);
    prox(1);
    prox(0);
    cfg(0, 0, 1);
    prox(2);
    report_and_stop;
  end
endmodule
bind pio_top pio_monitor i_mon (.CLOCK, .RESET, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .HWDATA, .HRDATA,
  .HREADYOUT, .HRESP, .PROX_VALID, .LIGHT_HI_EV, .LIGHT_LO_EV, .INT_N, .IRQ);
`default_nettype wire
